//--- logic/phpm_device.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module phpm_device (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // host port pins
  phpm_if.dev pins,
  // configuration straps
  input wire logic strap_bus16_in,
  input wire logic strap_ds_style_in,
  // configuration from the internal processor
  input wire logic cfg_wait_en_in,
  input wire logic cfg_wait_high_in,
  input wire logic cfg_wait_od_in,
  input wire logic cfg_swap_in,
  // mailbox data to and from the internal processor
  output logic wr_valid_out,
  output logic [phpm_pkg::DATA_W-1:0] wr_data_out,
  output logic [phpm_pkg::PAGE_W-1:0] page_out,
  output logic rd_req_out,
  input wire logic rd_valid_in,
  input wire logic [phpm_pkg::DATA_W-1:0] rd_data_in,
  // mailbox flags and interrupts
  input wire logic [phpm_pkg::FLAG_W-1:0] flag_clr_in,
  input wire logic [phpm_pkg::FLAG_W-1:0] host_mask_in,
  input wire logic [phpm_pkg::FLAG_W-1:0] dsp_mask_in,
  input wire logic [phpm_pkg::FLAG_W-1:0] dsp_ev_clr_in,
  output logic [phpm_pkg::FLAG_W-1:0] flags_out,
  output logic dsp_irq_out
);
  import phpm_pkg::*;

  if (FLAG_W != DATA_W || PAGE_W > 8) begin : g_chk
    $error("phpm_device needs word-wide flags and a byte-wide page");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = DATA_W + 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = {{(DATA_W + 2){1'b0}}, 4'hF};
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic [DATA_W-1:0] data_s;
  logic cs_n_s;
  logic sel_s;
  logic a_n_s;
  logic b_s;

  assign pin_raw = {strap_bus16_in, strap_ds_style_in, pins.port_data_bus,
                    pins.port_select_n, pins.cmd_data_sel, pins.write_strobe_n,
                    pins.read_strobe_n};

  phpm_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .d_in(pin_raw),
    .q_out(pin_s)
  );

  assign data_s = pin_s[DATA_W+3:4];
  assign cs_n_s = pin_s[3];
  assign sel_s = pin_s[2];
  assign a_n_s = pin_s[1];
  assign b_s = pin_s[0];

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  logic [1:0] strap_cnt_ff;
  logic bus16_ff;
  logic ds_ff;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_cnt_ff <= 2'h0;
      bus16_ff <= 1'b1;
      ds_ff <= 1'b0;
    end else if (strap_cnt_ff != STRAP_CNT) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_CNT - 2'h1) begin
        bus16_ff <= pin_s[SYNC_W-1];
        ds_ff <= pin_s[SYNC_W-2];
      end
    end
  end

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  function automatic logic [1:0] decode_strobe(input logic ds, input logic a_n,
                                               input logic b);
    logic [1:0] rw;
    rw = ds ? {!a_n && b, !a_n && !b} : {!b, !a_n};
    return rw;
  endfunction

  function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  phpm_dev_state_t state_ff;
  logic [3:0] op_ff;
  logic [7:0] remain_ff;
  logic [7:0] hold_ff;
  logic half_ff;
  logic [PAGE_W-1:0] page_ff;
  logic [FLAG_W-1:0] flags_ff;
  logic [FLAG_W-1:0] host_ev_ff;
  logic [FLAG_W-1:0] dsp_ev_ff;
  logic host_irq_ff;
  logic wait_busy_ff;
  logic acc_rd;
  logic acc_wr;
  logic acc_on;

  assign {acc_rd, acc_wr} = cs_n_s ? 2'b00 : decode_strobe(ds_ff, a_n_s, b_s);
  assign acc_on = acc_rd || acc_wr;

  logic wr_go;
  logic wr_done;
  logic is_cmd;
  logic cmd_reset;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] word_in;
  logic rd_go;
  logic st_rd;
  logic rd_second;
  logic rd_first;
  logic fetch;
  logic flag_rd;
  logic deliver;
  logic [DATA_W-1:0] rd_word;
  logic [FLAG_W-1:0] nxt_flags;
  logic [FLAG_W-1:0] flag_set;
  logic [DATA_W-1:0] status_word;

  assign wr_go = (state_ff == DEV_IDLE) && acc_wr;
  assign rd_go = (state_ff == DEV_IDLE) && acc_rd;
  assign wr_done = wr_go && (bus16_ff || half_ff);
  assign cmd_reset = wr_go && sel_s && (bus16_ff || !half_ff);
  assign is_cmd = sel_s || (remain_ff == 8'h00);
  assign wr_word = bus16_ff ? data_s : {hold_ff, data_s[7:0]};
  assign word_in = (!is_cmd && cfg_swap_in) ? swap_bytes(wr_word) : wr_word;
  assign st_rd = rd_go && sel_s;
  assign rd_second = rd_go && !sel_s && !bus16_ff && half_ff;
  assign rd_first = rd_go && !sel_s && !rd_second;
  assign fetch = rd_first && (op_ff == OP_READ) && (remain_ff != 8'h00);
  assign flag_rd = rd_first && (op_ff == OP_FLAG_READ) && (remain_ff != 8'h00);
  assign deliver = (rd_first && !fetch) || ((state_ff == DEV_FETCH) && rd_valid_in);

  always_comb begin
    rd_word = 16'h0000;
    if (state_ff == DEV_FETCH) begin
      rd_word = rd_data_in;
    end else if (flag_rd) begin
      rd_word = flags_ff;
    end
    if (cfg_swap_in) begin
      rd_word = swap_bytes(rd_word);
    end
  end

  assign status_word = {page_ff, 5'h00, remain_ff != 8'h00, host_irq_ff, wait_busy_ff};

  // ---------------------------------------------------------------
  // access sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= DEV_IDLE;
    end else begin
      unique case (state_ff)
        DEV_IDLE: begin
          if (fetch) begin
            state_ff <= DEV_FETCH;
          end else if (acc_on) begin
            state_ff <= DEV_HOLD;
          end
        end
        DEV_FETCH: begin
          if (rd_valid_in) begin
            state_ff <= DEV_HOLD;
          end
        end
        DEV_HOLD: begin
          if (!acc_on) begin
            state_ff <= DEV_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command interpreter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_ff <= OP_NONE;
      remain_ff <= 8'h00;
    end else if (wr_done && is_cmd) begin
      op_ff <= word_in[CMD_OP_LSB +: 4];
      remain_ff <= word_in[CMD_CNT_LSB +: 8];
    end else if (cmd_reset) begin
      op_ff <= OP_NONE;
      remain_ff <= 8'h00;
    end else if ((wr_done || rd_first) && remain_ff != 8'h00) begin
      remain_ff <= remain_ff - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // byte pairing and read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] dout_ff;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_ff <= 8'h00;
      half_ff <= 1'b0;
      dout_ff <= 16'h0000;
    end else if (cmd_reset && !bus16_ff) begin
      hold_ff <= data_s[7:0];
      half_ff <= 1'b1;
    end else if (wr_go) begin
      hold_ff <= data_s[7:0];
      half_ff <= !bus16_ff && !half_ff;
    end else if (st_rd) begin
      dout_ff <= status_word;
    end else if (rd_second) begin
      dout_ff <= {8'h00, hold_ff};
      half_ff <= 1'b0;
    end else if (deliver) begin
      dout_ff <= bus16_ff ? rd_word : {8'h00, rd_word[15:8]};
      hold_ff <= rd_word[7:0];
      half_ff <= !bus16_ff;
    end
  end

  assign pins.dev_data = dout_ff;
  assign pins.dev_data_oe_n = !(acc_rd && state_ff == DEV_HOLD);

  // ---------------------------------------------------------------
  // mailbox data and page
  // ---------------------------------------------------------------
  logic wr_valid_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic rd_req_ff;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_valid_ff <= 1'b0;
      wr_data_ff <= 16'h0000;
      rd_req_ff <= 1'b0;
      page_ff <= '0;
    end else begin
      wr_valid_ff <= wr_done && !is_cmd && (op_ff == OP_WRITE);
      rd_req_ff <= fetch;
      if (wr_done && !is_cmd) begin
        wr_data_ff <= word_in;
      end
      if (wr_done && !is_cmd && op_ff == OP_PAGE) begin
        page_ff <= word_in[PAGE_W-1:0];
      end
    end
  end

  assign wr_valid_out = wr_valid_ff;
  assign wr_data_out = wr_data_ff;
  assign rd_req_out = rd_req_ff;
  assign page_out = page_ff;

  // ---------------------------------------------------------------
  // mailbox flags and interrupts
  // ---------------------------------------------------------------
  assign flag_set = (wr_done && !is_cmd && op_ff == OP_FLAG_SET) ? word_in : '0;
  assign nxt_flags = (flags_ff & ~flag_clr_in) | flag_set;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_ff <= '0;
      host_ev_ff <= '0;
      dsp_ev_ff <= '0;
      host_irq_ff <= 1'b0;
      dsp_irq_out <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      host_ev_ff <= (host_ev_ff & ~(flag_rd ? flags_ff : '0)) | (flags_ff & ~nxt_flags);
      dsp_ev_ff <= (dsp_ev_ff & ~dsp_ev_clr_in) | (~flags_ff & nxt_flags);
      host_irq_ff <= |(host_ev_ff & ~host_mask_in);
      dsp_irq_out <= |(dsp_ev_ff & ~dsp_mask_in);
    end
  end

  assign flags_out = flags_ff;
  assign pins.host_int = host_irq_ff;

  // ---------------------------------------------------------------
  // wait strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_busy_ff <= 1'b0;
    end else begin
      wait_busy_ff <= !cs_n_s && state_ff != DEV_HOLD;
    end
  end

  assign pins.wait_out = wait_busy_ff ? cfg_wait_high_in : !cfg_wait_high_in;
  assign pins.wait_oe_n = !(cfg_wait_en_in && (!cfg_wait_od_in || wait_busy_ff));

endmodule // phpm_device

//--- logic/phpm_pkg.sv
package phpm_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int FLAG_W = 16;
  localparam int PAGE_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ON_NS = 35;
  localparam int T_OFF_NS = 10;
  localparam int T_ACC_NS = 100;
  localparam int ON_CYC = (T_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pin sync both ways plus device decode
  localparam int WAIT_LAT_CYC = 6;
  localparam int STROBE_MIN_CYC = (ON_CYC > WAIT_LAT_CYC) ? ON_CYC : WAIT_LAT_CYC;
  localparam int GAP_RAW_CYC = ACC_CYC - STROBE_MIN_CYC - 1;
  localparam int GAP_CYC = (GAP_RAW_CYC > OFF_CYC) ? GAP_RAW_CYC : OFF_CYC;
  localparam logic [3:0] STROBE_MIN_CNT = 4'(STROBE_MIN_CYC - 1);
  localparam logic [3:0] GAP_CNT = 4'(GAP_CYC - 1);
  localparam logic [1:0] STRAP_CNT = 2'h3;

  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int ST_WAIT_BIT = 0;
  localparam int ST_INT_BIT = 1;
  localparam int ST_CMDP_BIT = 2;
  localparam int ST_PAGE_LSB = 8;

  // ---------------------------------------------------------------
  // command word fields and operations
  // ---------------------------------------------------------------
  localparam int CMD_OP_LSB = 12;
  localparam int CMD_CNT_LSB = 0;
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_PAGE = 4'h3;
  localparam logic [3:0] OP_FLAG_SET = 4'h4;
  localparam logic [3:0] OP_FLAG_READ = 4'h5;

  // ---------------------------------------------------------------
  // controller registers
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ACCESS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam int CTRL_DS_BIT = 0;
  localparam int CTRL_USE_WAIT_BIT = 1;
  localparam int CTRL_WAIT_HI_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int ACC_SEL_BIT = 16;
  localparam int ACC_READ_BIT = 17;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_DEVINT_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;

  // ---------------------------------------------------------------
  // state machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DEV_IDLE, DEV_FETCH, DEV_HOLD} phpm_dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_SETUP, HOST_ON, HOST_OFF} phpm_host_state_t;

endpackage

//--- logic/phpm_if.sv
`timescale 1ns/1ps
interface phpm_if #(
  parameter logic WAIT_PULL = 1'b1
);
  // ---------------------------------------------------------------
  // pins; write_strobe_n doubles as data_strobe_n, read_strobe_n as
  // read_write_direction in the data strobe style
  // ---------------------------------------------------------------
  logic port_select_n;
  logic cmd_data_sel;
  logic write_strobe_n;
  logic read_strobe_n;
  logic [15:0] host_data;
  logic host_data_oe_n;
  logic [15:0] dev_data;
  logic dev_data_oe_n;
  logic [15:0] port_data_bus;
  logic wait_out;
  logic wait_oe_n;
  logic wait_strobe;
  logic host_int;

  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  assign port_data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 16'h0000);
  assign wait_strobe = !wait_oe_n ? wait_out : WAIT_PULL;

  modport dev (
    input port_select_n, cmd_data_sel, write_strobe_n, read_strobe_n, port_data_bus,
    output dev_data, dev_data_oe_n, wait_out, wait_oe_n, host_int
  );
  modport host (
    output port_select_n, cmd_data_sel, write_strobe_n, read_strobe_n, host_data,
    output host_data_oe_n,
    input port_data_bus, wait_strobe, host_int
  );
endinterface

//--- logic/phpm_sync.sv
`timescale 1ns/1ps
module phpm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  if (W < 1) begin : g_chk
    $error("phpm_sync width must be at least one");
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule // phpm_sync

//--- logic/phpm_host.sv
`timescale 1ns/1ps
module phpm_host (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // host port pins
  phpm_if.host pins,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // interrupt
  output logic irq_out
);
  import phpm_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W+1:0] pin_s;
  logic [DATA_W-1:0] data_s;
  logic wait_s;
  logic int_s;

  phpm_sync #(.W(DATA_W + 2), .RST_VAL({{DATA_W{1'b0}}, 2'b10})) u_sync (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .d_in({pins.port_data_bus, pins.wait_strobe, pins.host_int}),
    .q_out(pin_s)
  );

  assign data_s = pin_s[DATA_W+1:2];
  assign wait_s = pin_s[1];
  assign int_s = pin_s[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  phpm_host_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [2:0] ctrl_ff;
  logic [17:0] acc_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic int_prev_ff;
  logic wr_en;
  logic start;
  logic wait_act;
  logic done;
  logic is_rd;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign start = wr_en && paddr_in == REG_ACCESS && state_ff == HOST_IDLE;
  assign wait_act = ctrl_ff[CTRL_USE_WAIT_BIT] && (wait_s == ctrl_ff[CTRL_WAIT_HI_BIT]);
  assign done = state_ff == HOST_OFF && cnt_ff == GAP_CNT;
  assign is_rd = acc_ff[ACC_READ_BIT];

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= IRQ_MASK_RESET;
      acc_ff <= 18'h00000;
    end else begin
      if (wr_en && paddr_in == REG_CTRL) begin
        ctrl_ff <= pwdata_in[2:0];
      end
      if (wr_en && paddr_in == REG_IRQ_MASK) begin
        irq_mask_ff <= pwdata_in[1:0];
      end
      if (start) begin
        acc_ff <= pwdata_in[17:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= HOST_IDLE;
      cnt_ff <= 4'h0;
      rdata_ff <= 16'h0000;
    end else begin
      unique case (state_ff)
        HOST_IDLE: begin
          if (start) begin
            state_ff <= HOST_SETUP;
          end
        end
        HOST_SETUP: begin
          state_ff <= HOST_ON;
          cnt_ff <= 4'h0;
        end
        HOST_ON: begin
          if (cnt_ff != STROBE_MIN_CNT) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (!wait_act) begin
            state_ff <= HOST_OFF;
            cnt_ff <= 4'h0;
            if (is_rd) begin
              rdata_ff <= data_s;
            end
          end
        end
        HOST_OFF: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (done) begin
            state_ff <= HOST_IDLE;
          end
        end
      endcase
    end
  end

  logic drive;
  assign drive = state_ff == HOST_SETUP || state_ff == HOST_ON;
  assign pins.port_select_n = !drive;
  assign pins.cmd_data_sel = drive && acc_ff[ACC_SEL_BIT];
  assign pins.write_strobe_n = ctrl_ff[CTRL_DS_BIT] ? state_ff != HOST_ON
                                                    : !(state_ff == HOST_ON && !is_rd);
  assign pins.read_strobe_n = ctrl_ff[CTRL_DS_BIT] ? (!drive || is_rd)
                                                   : !(state_ff == HOST_ON && is_rd);
  assign pins.host_data = acc_ff[15:0];
  assign pins.host_data_oe_n = !(drive && !is_rd);

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_ff <= 2'h0;
      int_prev_ff <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      int_prev_ff <= int_s;
      irq_stat_ff <= (irq_stat_ff & ~((wr_en && paddr_in == REG_IRQ_STAT) ? pwdata_in[1:0] : 2'h0))
                     | {int_s && !int_prev_ff, done};
      irq_out <= |(irq_stat_ff & ~irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // apb read
  // ---------------------------------------------------------------
  always_comb begin
    prdata_out = 32'h00000000;
    if (psel_in && !pwrite_in) begin
      unique case (paddr_in)
        REG_CTRL: prdata_out = {29'h00000000, ctrl_ff};
        REG_ACCESS: prdata_out = {14'h0000, acc_ff};
        REG_STATUS: prdata_out = {29'h00000000, int_s, wait_act, state_ff != HOST_IDLE};
        REG_RDATA: prdata_out = {16'h0000, rdata_ff};
        REG_IRQ_STAT: prdata_out = {30'h00000000, irq_stat_ff};
        REG_IRQ_MASK: prdata_out = {30'h00000000, irq_mask_ff};
        default: prdata_out = 32'h00000000;
      endcase
    end
  end

  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

endmodule // phpm_host

//--- tb/phpm_asserts.sv
`timescale 1ns/1ps
module phpm_asserts (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // pins
  input wire logic port_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic wait_oe_n,
  input wire logic wait_strobe
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_strobe_qualified: assert property (
    (!write_strobe_n || !read_strobe_n) |-> !port_select_n) else $error("strobe unselected");
  a_hold_on_wait: assert property (
    (!port_select_n && !wait_strobe) |=> !port_select_n) else $error("released in wait");
  a_strobe_width: assert property (
    $fell(write_strobe_n) |-> (!write_strobe_n)[*6]) else $error("strobe too short");
  a_idle_gap: assert property (
    $rose(port_select_n) |-> port_select_n[*3]) else $error("gap too short");
  a_single_driver: assert property (
    !host_data_oe_n |-> dev_data_oe_n) else $error("bus contention");
  a_host_drive_wr: assert property (
    !host_data_oe_n |-> read_strobe_n) else $error("host drives on read");
  a_float_idle: assert property (
    port_select_n[*5] |-> dev_data_oe_n) else $error("bus driven unselected");
  a_float_reset: assert property (
    !$past(arst_n_in) |-> wait_oe_n && dev_data_oe_n) else $error("pin driven at reset");
endmodule // phpm_asserts

//--- tb/phpm_tb.sv
`timescale 1ns/1ps
module parallel_host_port_mailbox_tb;
  import phpm_pkg::*;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, irq, wr_valid, rd_req, dsp_irq, cfg_wait_en = 1'b0, cfg_swap = 1'b0;
  logic rd_valid = 1'b0, bus16 = 1'b1;
  logic [7:0] paddr = 8'h00, page;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] wr_data, flags, flag_clr = 16'h0, host_mask = 16'h0, dsp_mask = 16'h0;
  logic [15:0] wq[$];
  logic [15:0] exp_w[7] = '{16'h0A0B, 16'h0C0D, 16'h1234, 16'h5555, 16'h6666, 16'h7777, 16'hB2A1};
  int error_cnt = 0, compares = 0;
  phpm_if i_phpm_if ();
  phpm_device i_phpm_device (.clk_sys_in, .arst_n_in, .pins(i_phpm_if), .strap_bus16_in(bus16),
    .strap_ds_style_in(1'b0), .cfg_wait_en_in(cfg_wait_en), .cfg_wait_high_in(1'b0),
    .cfg_wait_od_in(1'b0), .cfg_swap_in(cfg_swap), .wr_valid_out(wr_valid),
    .wr_data_out(wr_data), .page_out(page), .rd_req_out(rd_req), .rd_valid_in(rd_valid),
    .rd_data_in(16'hBEEF), .flag_clr_in(flag_clr), .host_mask_in(host_mask),
    .dsp_mask_in(dsp_mask), .dsp_ev_clr_in(flag_clr), .flags_out(flags), .dsp_irq_out(dsp_irq));
  phpm_host i_phpm_host (.clk_sys_in, .arst_n_in, .pins(i_phpm_if), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(), .irq_out(irq));
  phpm_asserts u_chk (.clk_sys_in, .arst_n_in, .port_select_n(i_phpm_if.port_select_n),
    .write_strobe_n(i_phpm_if.write_strobe_n), .read_strobe_n(i_phpm_if.read_strobe_n),
    .host_data_oe_n(i_phpm_if.host_data_oe_n), .dev_data_oe_n(i_phpm_if.dev_data_oe_n),
    .wait_oe_n(i_phpm_if.wait_oe_n), .wait_strobe(i_phpm_if.wait_strobe));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    rd_valid <= rd_req;
    if (wr_valid) wq.push_back(wr_data);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pin(input logic sel, input logic rd, input logic [15:0] d);
    apb(1'b1, REG_ACCESS, {14'h0, rd, sel, d});
    do apb(1'b0, REG_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #300us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    apb(1'b0, REG_IRQ_MASK, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, REG_CTRL, 32'h2);
    cfg_wait_en <= 1'b1;
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    pin(1'b1, 1'b0, 16'h1002);
    pin(1'b0, 1'b0, 16'h0A0B);
    pin(1'b0, 1'b0, 16'h0C0D);
    pin(1'b0, 1'b0, 16'h1001);
    pin(1'b0, 1'b0, 16'h1234);
    pin(1'b1, 1'b0, 16'h1003);
    pin(1'b0, 1'b0, 16'h5555);
    pin(1'b1, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q & 32'hFFFE, 32'h4);
    pin(1'b0, 1'b0, 16'h6666);
    pin(1'b1, 1'b0, 16'h1001);
    pin(1'b0, 1'b0, 16'h7777);
    cfg_swap <= 1'b1;
    pin(1'b1, 1'b0, 16'h1001);
    pin(1'b0, 1'b0, 16'hA1B2);
    cfg_swap <= 1'b0;
    for (int i = 0; i < 7; i++) chk({16'h0, wq[i]}, {16'h0, exp_w[i]});
    pin(1'b1, 1'b0, 16'h2001);
    pin(1'b0, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'hBEEF);
    pin(1'b1, 1'b0, 16'h4001);
    pin(1'b0, 1'b0, 16'h0003);
    @(negedge clk_sys_in);
    chk({flags, 15'h0, dsp_irq}, 32'h00030001);
    @(posedge clk_sys_in);
    flag_clr <= 16'h0001;
    @(posedge clk_sys_in);
    flag_clr <= 16'h0000;
    repeat (6) @(posedge clk_sys_in);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, REG_IRQ_STAT, 32'h3);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    pin(1'b1, 1'b0, 16'h4001);
    pin(1'b0, 1'b0, 16'h0000);
    pin(1'b1, 1'b0, 16'h5001);
    pin(1'b0, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'h2);
    pin(1'b1, 1'b0, 16'h3001);
    pin(1'b0, 1'b0, 16'h0005);
    pin(1'b1, 1'b0, 16'h1002);
    pin(1'b0, 1'b0, 16'h0001);
    pin(1'b0, 1'b0, 16'h00C3);
    pin(1'b1, 1'b0, 16'h4001);
    pin(1'b0, 1'b0, 16'h0001);
    chk({wq[7], wq[8]}, 32'h000100C3);
    chk({8'h0, page, flags}, 32'h00050003);
    pin(1'b1, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q & 32'hFFFE, 32'h0502);
    apb(1'b1, REG_IRQ_MASK, 32'h3);
    dsp_mask <= 16'hFFFF;
    repeat (2) @(negedge clk_sys_in);
    chk({30'h0, dsp_irq, irq}, 32'h0);
    @(posedge clk_sys_in);
    arst_n_in <= 1'b0;
    cfg_wait_en <= 1'b0;
    bus16 <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    apb(1'b1, REG_CTRL, 32'h2);
    cfg_wait_en <= 1'b1;
    pin(1'b1, 1'b0, 16'h0020);
    pin(1'b1, 1'b0, 16'h0001);
    pin(1'b0, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'h000000BE);
    pin(1'b0, 1'b1, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'h000000EF);
    tally_and_finish();
  end
endmodule // parallel_host_port_mailbox_tb
